/* rtl/afc_device.sv */
// Contract
// [R1] strobe select bit picks manual or automatic
// [R2] host strobes each manual measurement
// [R3] each cycle corrects toward true offset
// [R4] status bit five flags cycle done
// [R5] auto update needs quality and repeat
// [R6] offset in status, applied to synthesizer
// [R7] mode 00 leaves host in control; the device still runs automatic updates in mode 00 when strobe select is set
// [R8] mode 01 measures once after reset
// [R9] mode 10 drops offset on signal loss
// [R10] mode 11 keeps offset after cycle
// [R11] offset is signed two's complement
// [R12] host clears enable before reading status
// [R13] transmitter sends slow preamble first
// [R14] drop for many senders, keep for one
// [R15] reset clears offset and done flag
//
// Purpose: measures the receive frequency offset and corrects the synthesizer
// Assumes: freq_error is the raw signed error in synthesizer steps, same clock
// Notes:   a measurement lasts MEAS_CYCLES enabled clocks
`timescale 1ns/1ns
`default_nettype none
module afc_device #(
    parameter int MEAS_LEN = afc_pkg::MEAS_CYCLES
) (
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire logic                        clk_en,
    afc_if.device                            link,
    input  wire logic                        signal_quality_indicator,
    input  wire logic signed [afc_pkg::OFF_W-1:0] freq_error,
    output logic signed [afc_pkg::OFF_W-1:0] synth_correction
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {S_IDLE, S_MEAS} afc_state_t;
    afc_state_t  state_r;
    logic [7:0]  ctrl_r;
    logic [15:0] cnt_r;
    logic        qual_ok_r;
    logic        once_done_r;
    logic        have_prev_r;
    logic signed [afc_pkg::OFF_W-1:0] prev_r;
    logic signed [afc_pkg::OFF_W-1:0] offset_value_r;
    logic        measure_cycle_done_r;
    logic        manual;
    afc_pkg::afc_mode_t mode;
    logic        start;
    logic        meas_end;
    logic signed [afc_pkg::OFF_W:0] step;
    logic signed [afc_pkg::OFF_W:0] sum;

    assign mode   = afc_pkg::afc_mode_t'(ctrl_r[afc_pkg::CTL_MODE_HI:afc_pkg::CTL_MODE_LO]);
    assign manual = !ctrl_r[afc_pkg::CTL_STROBE_SEL];                 // see [R1] [R7]
    // manual waits for host strobe; auto free-runs, once mode only until it is done
    assign start  = (state_r == S_IDLE) && (manual ? link.strobe     // see [R2]
                  : !(mode == afc_pkg::MODE_ONCE && once_done_r));    // see [R8]
    assign meas_end = (state_r == S_MEAS) && (cnt_r == 16'(MEAS_LEN - 1));
    // half of residual error each cycle: converges about 50, 75, 88 percent
    // widen both operands first: a four-bit difference would wrap for large errors
    assign step = ((afc_pkg::OFF_W+1)'(freq_error)
                  - (afc_pkg::OFF_W+1)'(offset_value_r)) >>> 1;       // see [R3]
    assign sum  = (afc_pkg::OFF_W+1)'(offset_value_r) + step;

    ////////////////////////////////////////////////////////////////////////////
    // control register capture
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_r <= afc_pkg::CTL_RESET;
        end else if (clk_en && link.control_load) begin
            ctrl_r <= link.control;
        end
    end

    // measurement sequencer and quality watch over the cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r   <= S_IDLE;
            cnt_r     <= 16'h0000;
            qual_ok_r <= 1'b0;
        end else if (clk_en) begin
            case (state_r)
                S_IDLE: begin
                    if (start) begin
                        state_r   <= S_MEAS;
                        cnt_r     <= 16'h0000;
                        qual_ok_r <= signal_quality_indicator;
                    end
                end
                S_MEAS: begin
                    qual_ok_r <= qual_ok_r & signal_quality_indicator; // see [R5]
                    if (meas_end) begin
                        state_r <= S_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // offset register, done flag and automatic mode bookkeeping
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            offset_value_r       <= afc_pkg::OFFSET_RESET;            // see [R15]
            measure_cycle_done_r <= 1'b0;                             // see [R15]
            once_done_r          <= 1'b0;
            have_prev_r          <= 1'b0;
            prev_r               <= afc_pkg::OFFSET_RESET;
        end else if (clk_en) begin
            if (start) begin
                measure_cycle_done_r <= 1'b0;
            end
            if (meas_end) begin
                measure_cycle_done_r <= 1'b1;                         // see [R4]
                if (manual) begin
                    offset_value_r <= afc_pkg::OFF_W'(sum);           // see [R3] [R11]
                end else if (qual_ok_r && signal_quality_indicator) begin
                    prev_r      <= freq_error;
                    have_prev_r <= 1'b1;
                    // two equal results in a row before the register moves
                    if (have_prev_r && prev_r == freq_error) begin    // see [R5]
                        offset_value_r <= freq_error;
                        once_done_r    <= 1'b1;                       // see [R8]
                    end
                end else begin
                    have_prev_r <= 1'b0;
                end
            end
            // drop mode clears the offset and the repeat history as soon as the signal goes away
            if (!manual && mode == afc_pkg::MODE_DROP && !signal_quality_indicator) begin
                offset_value_r <= afc_pkg::OFFSET_RESET;              // see [R9]
                have_prev_r    <= 1'b0;
            end
            // keep mode (and once) simply never clear the register, see [R10]
        end
    end

    // outputs registered; correction only applied while enabled
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            synth_correction <= afc_pkg::OFFSET_RESET;
            link.status_word <= 8'h00;
        end else if (clk_en) begin
            synth_correction <= ctrl_r[afc_pkg::CTL_OFFSET_EN] ? offset_value_r
                                                               : afc_pkg::OFFSET_RESET; // see [R6]
            link.status_word <= {2'b00, measure_cycle_done_r, 1'b0, offset_value_r};   // see [R6]
        end
    end
endmodule // afc_device
`default_nettype wire

/* rtl/afc_host.sv */
// Purpose: host end: apb slave registers driving the correction link
// Assumes: apb with 32-bit data, zero wait states
// Notes:   ctrl write issues a control load; cmd write bit0 gives a strobe
`timescale 1ns/1ns
`default_nettype none
module afc_host (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        clk_en,
    afc_if.host              link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    logic acc;
    logic wr;
    assign acc = psel && penable && clk_en;
    assign wr  = acc && pwrite;

    ////////////////////////////////////////////////////////////////////////////
    // writes turn into link pulses; strobe on a cmd write with bit0 set, the device uses it only in manual, see [R2]
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.control      <= afc_pkg::CTL_RESET;
            link.control_load <= 1'b0;
            link.strobe       <= 1'b0;
        end else if (clk_en) begin
            link.control_load <= 1'b0;
            link.strobe       <= 1'b0;
            if (wr && paddr == afc_pkg::ADDR_CTRL) begin
                link.control      <= pwdata[7:0];
                link.control_load <= 1'b1;
            end
            if (wr && paddr == afc_pkg::ADDR_CMD) begin
                link.strobe <= pwdata[afc_pkg::CMD_STROBE];           // see [R2]
            end
        end
    end

    // read data and answer; unmapped addresses answer with slverr
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr != afc_pkg::ADDR_CTRL
                       && paddr != afc_pkg::ADDR_CMD && paddr != afc_pkg::ADDR_STATUS;
            case (paddr)
                afc_pkg::ADDR_CTRL:   prdata <= {24'h000000, link.control};
                afc_pkg::ADDR_STATUS: prdata <= {24'h000000, link.status_word}; // see [R12]
                default:              prdata <= 32'h00000000;
            endcase
        end
    end
endmodule // afc_host
`default_nettype wire

/* rtl/afc_if.sv */
// Purpose: link between host and frequency correction device
// Assumes: one clock shared by both ends
// Notes:   control is loaded with a one-cycle pulse, strobe is a pulse
`timescale 1ns/1ns
`default_nettype none
interface afc_if;
    logic [7:0] control;      // correction control register value
    logic       control_load; // one-cycle load pulse
    logic       strobe;       // manual measure strobe pulse
    logic [7:0] status_word;  // status from device
    modport device (input control, input control_load, input strobe, output status_word);
    modport host   (output control, output control_load, output strobe, input status_word);
endinterface
`default_nettype wire

/* rtl/afc_pkg.sv */
// Purpose: shared constants for the frequency correction device and its host end
// Assumes: 100 MHz clock, registers of the host reached over apb
// Notes:   control byte and status word layouts live here; the checks and the status packing repeat their bit positions
package afc_pkg;
    // correction control register fields
    localparam int CTL_W           = 8;
    localparam int CTL_OFFSET_EN   = 0;
    localparam int CTL_STROBE_SEL  = 3;
    localparam int CTL_MODE_LO     = 6;
    localparam int CTL_MODE_HI     = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // status word fields
    localparam int STS_W           = 8;
    localparam int STS_OFF_LO      = 0;
    localparam int STS_OFF_HI      = 3;
    localparam int STS_DONE        = 5;
    localparam logic [3:0] OFFSET_RESET = 4'h0;
    // measurement timing and offset width
    localparam int MEAS_CYCLES     = 16;
    localparam int OFF_W           = 4;
    // host apb map
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CMD    = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int CMD_STROBE      = 0;
    localparam int CMD_LOAD        = 1;
    // auto modes
    typedef enum logic [1:0] {
        MODE_OFF  = 2'b00,
        MODE_ONCE = 2'b01,
        MODE_DROP = 2'b10,
        MODE_KEEP = 2'b11
    } afc_mode_t;
endpackage

/* test/afc_asserts.sv */
// Purpose: protocol checks on the frequency correction link
// Assumes: one clock, rst async high, MEAS_LEN as on the device
// Notes:   manual means strobe select clear and auto modes off
`timescale 1ns/1ns
`default_nettype none
module afc_asserts #(parameter int MEAS_LEN = 16) (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [7:0] control,
    input wire logic       control_load,
    input wire logic       strobe,
    input wire logic [7:0] status_word,
    input wire logic       signal_quality_indicator
);
    localparam int DW = MEAS_LEN + 4; // margin for start and status lag
    logic [1:0] mode;
    logic       man;
    // decode mode and manual once for the checks; a_auto_hold reads strobe select itself
    assign mode = control[7:6];
    assign man  = !control[3] && mode == 2'b00;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
////////////////////////////////////////////////////////////////////////////////
    a_rst_clear: assert property ($fell(rst) |-> status_word == 8'h00)
        else $error("status not clear after reset");
    a_manual_done: assert property (man && strobe |-> ##[1:DW] status_word[5])
        else $error("manual measurement never flagged done");
    a_manual_only: assert property (man && $stable(control) && $changed(status_word[3:0])
        |-> $rose(status_word[5])) else $error("offset moved without a measurement");
    a_once_stops: assert property (mode == 2'b01 && status_word[3:0] != 4'h0
        && $stable(control) |=> $stable(status_word[3:0])) else $error("once mode updated twice");
    a_drop_clear: assert property (mode == 2'b10 && !signal_quality_indicator
        && $stable(control) |-> ##[1:3] status_word[3:0] == 4'h0) else $error("offset not dropped");
    a_auto_hold: assert property ((control[3] && mode != 2'b10 && !signal_quality_indicator)[*3]
        |=> $stable(status_word[3:0])) else $error("offset moved without signal");
    a_load_pair: assert property ($changed(control) |-> control_load || $past(control_load))
        else $error("control changed without load");
    a_strobe_pulse: assert property (strobe |=> !strobe)
        else $error("strobe longer than one cycle");
endmodule // afc_asserts
`default_nettype wire

/* test/testbench.sv */
// Purpose: drives the host over apb and the device inputs directly, and checks against a model
// Assumes: clk_en held high so measure timing stays fixed
// Notes:   MEAS_LEN cut to 4 to keep the run short
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int L = 4;
    logic clock, rst, clk_en, signal_quality_indicator, er;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic signed [3:0] freq_error, synth_correction;
    logic [15:0] lf;
    int err_count, check_count, off, o;
    afc_if lk();
    afc_device #(.MEAS_LEN(L)) afc_device_inst (.clock, .rst, .clk_en, .link(lk),
        .signal_quality_indicator, .freq_error, .synth_correction);
    afc_host afc_host_inst (.clock, .rst, .clk_en, .link(lk), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    afc_asserts #(.MEAS_LEN(L)) afc_asserts_inst (.clock, .rst, .control(lk.control),
        .control_load(lk.control_load), .strobe(lk.strobe),
        .status_word(lk.status_word), .signal_quality_indicator);
////////////////////////////////////////////////////////////////////////////////
    // free running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rs();
        apb(1'b0, afc_pkg::ADDR_STATUS, 32'h0);
    endtask
    task automatic rst_all();
        @(posedge clock);
        rst <= 1'b1;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        off = 0;
    endtask
    // done drops at the start of a measurement, then rises at its end
    task automatic wdone();
        int i;
        for (i = 0; i < 20 && lk.status_word[5] === 1'b1; i++) @(posedge clock);
        for (i = 0; i < 60 && lk.status_word[5] !== 1'b1; i++) @(posedge clock);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    // main sequence: manual runs, unmapped access, then the auto modes
    initial begin
        {rst, clk_en, signal_quality_indicator, psel, penable, pwrite} = 6'h30;
        {paddr, pwdata, freq_error} = 44'h0;
        lf = 16'h8D76;
        err_count = 0;
        check_count = 0;
        for (int r = 0; r < 2; r++) begin
            rst_all();
            rs();
            chk("status", 32'h0, {24'h0, rd[7:0]});
            lf = nxt(lf);
            freq_error <= lf[3:0];
            apb(1'b1, afc_pkg::ADDR_CTRL, 32'h01);
            apb(1'b0, afc_pkg::ADDR_CTRL, 32'h0);
            chk("control", 32'h01, rd);
            repeat (3) begin
                apb(1'b1, afc_pkg::ADDR_CMD, 32'h01);
                wdone();
                off = off + ((int'(freq_error) - off) >>> 1);
                rs();
                chk("done", 1, rd[5]);
                chk("offset", off & 15, rd[3:0]);
                chk("correction", off & 15, $unsigned(synth_correction));
            end
            apb(1'b1, afc_pkg::ADDR_CTRL, 32'h00);
            rs();
            chk("read offset", off & 15, rd[3:0]);
            chk("idle correction", 0, $unsigned(synth_correction));
            $display("test manual run %0d done", r);
        end
        apb(1'b0, 8'hFC, 32'h0);
        chk("slverr", 1, er);
        for (int m = 1; m < 4; m++) begin
            rst_all();
            lf = nxt(lf);
            freq_error <= lf[3:0];
            signal_quality_indicator <= 1'b1;
            apb(1'b1, afc_pkg::ADDR_CTRL, {24'h0, m[1:0], 6'h09});
            repeat (8 * L + 20) @(posedge clock);
            rs();
            o = rd[3:0];
            chk("auto first", {28'h0, lf[3:0]}, rd[3:0]);
            chk("auto correction", {28'h0, lf[3:0]}, $unsigned(synth_correction));
            freq_error <= ~lf[3:0];
            signal_quality_indicator <= (m == 1);
            repeat (8 * L + 20) @(posedge clock);
            rs();
            chk("auto offset", (m == 2) ? 32'h0 : {28'h0, lf[3:0]}, rd[3:0]);
            $display("test auto mode %0d done", m);
        end
        summarize();
    end
    // watchdog well beyond the expected run length
    initial begin
        repeat (5000) @(posedge clock);
        err_count++;
        summarize();
    end
endmodule // testbench
`default_nettype wire
